// ---- rtl/fsp_defines.svh ----
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// Command frame constants.
`define FSP_CMD_CODE        8'h5f
`define FSP_SW1             8'h91
`define FSP_SW2_OK          8'h00
`define FSP_SW2_PARAM       8'h9e
`define FSP_SW2_LENGTH      8'h7e
`define FSP_SW2_NO_FILE     8'hf0

// Field layouts.
`define FSP_FNUM_RSV_MASK   8'he0
`define FSP_FOPT_RSV_MASK   8'hbc
`define FSP_FOPT_DM_BIT     6
`define FSP_FOPT_MODE_MSB   1
`define FSP_DOPT_RSV_MASK   8'h06
`define FSP_DOPT_ID_BIT     7
`define FSP_DOPT_CTR_BIT    6
`define FSP_RIGHT_KEY_MAX   4'h4
`define FSP_RIGHT_PLAIN     4'he
`define FSP_RIGHT_NONE      4'hf
`define FSP_OFF_LAST        2'h2

// Register byte addresses.
`define FSP_REG_CTRL        8'h00
`define FSP_REG_SEL         8'h04
`define FSP_REG_ENTRY       8'h08
`define FSP_REG_STATUS      8'h0c
`define FSP_REG_RESULT      8'h10

// Reset values.
`define FSP_CTRL_EN_RST     1'b1

`endif

// ---- rtl/fsp_pkg.sv ----
package fsp_pkg;

    typedef enum logic [3:0] {
        FSP_IDLE, FSP_FNUM, FSP_FOPT, FSP_ACC0, FSP_ACC1, FSP_DOPT,
        FSP_DACC0, FSP_DACC1, FSP_IDOFF, FSP_CTROFF, FSP_TAIL
    } fsp_state_t;

    typedef enum logic [1:0] {
        FSP_META_OFF, FSP_META_PLAIN, FSP_META_ENC
    } fsp_meta_t;

    typedef struct packed {
        logic        exists;
        logic        full;
        logic [23:0] size;
    } fsp_file_ent_t;

    typedef struct packed {
        fsp_state_t    st;
        logic          foreign;
        logic          perr;
        logic [1:0]    cnt;
        logic [4:0]    fnum;
        logic [7:0]    fopt;
        logic [15:0]   acc;
        logic [7:0]    dopt;
        logic [15:0]   dacc;
        logic [23:0]   idoff;
        logic [23:0]   ctroff;
        logic [5:0]    dm_feat;
        fsp_meta_t     meta;
        logic [3:0]    meta_key;
        logic          full;
        logic          ctrl_en;
        logic [4:0]    sel;
        logic [31:0]   rdata;
        logic          resp_valid;
        logic [15:0]   resp_status;
        logic          upd_valid;
        logic [7:0]    last_code;
        logic          mem_we;
        logic [4:0]    mem_wa;
        fsp_file_ent_t mem_wd;
    } fsp_vec_t;

endpackage : fsp_pkg

// ---- rtl/fsp_mem_if.sv ----
`timescale 1ns/1ps
interface fsp_mem_if;
    import fsp_pkg::*;

    logic [4:0]    rd_addr;
    fsp_file_ent_t rd_data;
    logic          we;
    logic [4:0]    wr_addr;
    fsp_file_ent_t wr_data;

    modport ctrl (output rd_addr, output we, output wr_addr,
                  output wr_data, input rd_data);
    modport mem  (input rd_addr, input we, input wr_addr,
                  input wr_data, output rd_data);
endinterface : fsp_mem_if

// ---- rtl/fsp_file_table.sv ----
`timescale 1ns/1ps
module fsp_file_table
    import fsp_pkg::*;
#(
    parameter int FILES = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    fsp_mem_if.mem   m
);

    typedef struct packed {
        fsp_file_ent_t [FILES-1:0] ent;
        fsp_file_ent_t             rd;
    } fsp_tab_t;

    fsp_tab_t q;
    fsp_tab_t d;

    if (FILES < 1 || FILES > 32) begin : g_chk
        $error("fsp_file_table: FILES must lie in 1..32");
    end

    // Unknown file numbers read as an absent file.
    always_comb begin
        d = q;
        d.rd = '0;
        if (32'(m.rd_addr) < FILES) begin
            d.rd = q.ent[m.rd_addr];
        end
        if (m.we && 32'(m.wr_addr) < FILES) begin
            d.ent[m.wr_addr] = m.wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign m.rd_data = q.rd;

endmodule : fsp_file_table

// ---- rtl/fsp_parser.sv ----
`timescale 1ns/1ps
`include "fsp_defines.svh"
// Overview of operation
// - Code 5Fh changes settings of an existing file; absent files rejected.
// - Framing plain or full follows the file's current right, not new.
// - Option byte: bits 7,5-2 reserved zero; bits 1-0 new comm mode.
// - Option bit 6 switches dynamic messaging and mirroring on or off.
// - Dynamic option byte present only when option bit 6 is set.
// - Dynamic options: id, counter, limit, encrypted, tamper, reserved, ASCII.
// - Dynamic access word: meta, file-read, fixed Fh, counter-retrieve.
// - Meta nibble: 0h-4h keyed mirroring, Eh plain, Fh none.
// - Identifier offset, 3 bytes LSB first, if id mirror and meta Eh.
// - Counter offset, 3 bytes LSB first, if counter on and meta Eh.
// - Success returns only 9100h; failure returns 91h with error code.
module fsp_parser
    import fsp_pkg::*;
#(
    parameter int FILES   = 32,
    parameter int ID_LEN  = 7,
    parameter int CTR_LEN = 3
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    input  wire logic        rx_valid,
    input  wire logic        rx_first,
    input  wire logic        rx_last,
    input  wire logic [7:0]  rx_byte,
    output logic             resp_valid,
    output logic      [15:0] resp_status,
    output logic             upd_valid,
    output logic      [4:0]  target_file_number,
    output logic      [7:0]  file_option_byte,
    output logic      [15:0] file_access_word,
    output logic      [7:0]  dyn_msg_option_byte,
    output logic      [15:0] dyn_msg_access_word,
    output logic      [5:0]  dyn_msg_features,
    output fsp_meta_t        meta_read_mode,
    output logic      [3:0]  meta_read_key,
    output logic      [23:0] identifier_mirror_offset,
    output logic      [23:0] read_counter_mirror_offset,
    output logic             fully_protected_framing
);

    if (ID_LEN < 1 || ID_LEN > 255) begin : g_chk_id_len
        $error("fsp_parser: ID_LEN must lie in 1..255");
    end
    if (CTR_LEN < 1 || CTR_LEN > 255) begin : g_chk_ctr_len
        $error("fsp_parser: CTR_LEN must lie in 1..255");
    end
    if (FILES < 1 || FILES > 32) begin : g_chk_files
        $error("fsp_parser: FILES must lie in 1..32");
    end

    fsp_vec_t q;
    fsp_vec_t d;

    fsp_mem_if mif ();

    fsp_file_table #(
        .FILES (FILES)
    ) u_table (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .m   (mif.mem)
    );

    // A nibble naming one of the application keys.
    function automatic logic key_ok(input logic [3:0] n);
        return n <= `FSP_RIGHT_KEY_MAX;
    endfunction : key_ok

    // A mirror field is sent only for plain meta mirroring.
    function automatic logic mirror_here(input logic en,
                                         input logic [3:0] meta);
        return en && (meta == `FSP_RIGHT_PLAIN);
    endfunction : mirror_here

    // An offset must leave room for the mirrored value inside the file.
    function automatic logic off_ok(input logic [23:0] off,
                                    input logic [23:0] size,
                                    input logic [23:0] len);
        return ({1'b0, off} + {1'b0, len}) <= {1'b0, size};
    endfunction : off_ok

    fsp_state_t nxt;
    logic [7:0] code;
    logic       id_here;
    logic       ctr_here;
    logic       range_bad;

    always_comb begin
        d         = q;
        nxt       = q.st;
        code      = `FSP_SW2_OK;
        id_here   = 1'b0;
        ctr_here  = 1'b0;
        range_bad = 1'b0;
        d.resp_valid = 1'b0;
        d.upd_valid  = 1'b0;
        d.mem_we     = 1'b0;
        d.rdata      = '0;

        // Register writes.
        if (bus_wr) begin
            case (bus_addr)
                `FSP_REG_CTRL: begin
                    d.ctrl_en = bus_wdata[0];
                end
                `FSP_REG_SEL: begin
                    d.sel = bus_wdata[4:0];
                end
                `FSP_REG_ENTRY: begin
                    d.mem_we = 1'b1;
                    d.mem_wa = q.sel;
                    d.mem_wd = fsp_file_ent_t'(bus_wdata[25:0]);
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses read zero.
        if (bus_rd) begin
            case (bus_addr)
                `FSP_REG_CTRL: begin
                    d.rdata = {31'h0, q.ctrl_en};
                end
                `FSP_REG_SEL: begin
                    d.rdata = {27'h0, q.sel};
                end
                `FSP_REG_STATUS: begin
                    d.rdata = {16'h0, q.last_code, 7'h0,
                               q.st != FSP_IDLE};
                end
                `FSP_REG_RESULT: begin
                    d.rdata = {3'h0, q.fnum, q.fopt, q.acc};
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end

        // Command byte stream.
        if (rx_valid && q.ctrl_en) begin
            if (rx_first) begin
                d.foreign  = rx_byte != `FSP_CMD_CODE;
                d.perr     = 1'b0;
                d.cnt      = '0;
                d.fopt     = '0;
                d.acc      = '0;
                d.dopt     = '0;
                d.dacc     = '0;
                d.idoff    = '0;
                d.ctroff   = '0;
                d.dm_feat  = '0;
                d.meta     = FSP_META_OFF;
                d.meta_key = '0;
                nxt = d.foreign ? FSP_TAIL : FSP_FNUM;
            end else begin
                case (q.st)
                    FSP_FNUM: begin
                        d.fnum = rx_byte[4:0];
                        if ((rx_byte & `FSP_FNUM_RSV_MASK) != 8'h00) begin
                            d.perr = 1'b1;
                        end
                        nxt = FSP_FOPT;
                    end
                    FSP_FOPT: begin
                        d.fopt = rx_byte;
                        d.full = mif.rd_data.full;
                        if ((rx_byte & `FSP_FOPT_RSV_MASK) != 8'h00) begin
                            d.perr = 1'b1;
                        end
                        nxt = FSP_ACC0;
                    end
                    FSP_ACC0: begin
                        d.acc[7:0] = rx_byte;
                        nxt = FSP_ACC1;
                    end
                    FSP_ACC1: begin
                        d.acc[15:8] = rx_byte;
                        nxt = q.fopt[`FSP_FOPT_DM_BIT] ? FSP_DOPT
                                                       : FSP_TAIL;
                    end
                    FSP_DOPT: begin
                        d.dopt    = rx_byte;
                        d.dm_feat = {rx_byte[7:3], rx_byte[0]};
                        if ((rx_byte & `FSP_DOPT_RSV_MASK) != 8'h00) begin
                            d.perr = 1'b1;
                        end
                        nxt = FSP_DACC0;
                    end
                    FSP_DACC0: begin
                        d.dacc[7:0] = rx_byte;
                        nxt = FSP_DACC1;
                    end
                    FSP_DACC1: begin
                        d.dacc[15:8] = rx_byte;
                        if (key_ok(rx_byte[7:4])) begin
                            d.meta     = FSP_META_ENC;
                            d.meta_key = rx_byte[7:4];
                        end else if (rx_byte[7:4] == `FSP_RIGHT_PLAIN) begin
                            d.meta = FSP_META_PLAIN;
                        end else if (rx_byte[7:4] == `FSP_RIGHT_NONE) begin
                            d.meta = FSP_META_OFF;
                        end else begin
                            d.perr = 1'b1;
                        end
                        if (!key_ok(rx_byte[3:0]) &&
                            rx_byte[3:0] != `FSP_RIGHT_NONE) begin
                            d.perr = 1'b1;
                        end
                        if (q.dacc[7:4] != `FSP_RIGHT_NONE) begin
                            d.perr = 1'b1;
                        end
                        if (!key_ok(q.dacc[3:0]) &&
                            q.dacc[3:0] != `FSP_RIGHT_PLAIN &&
                            q.dacc[3:0] != `FSP_RIGHT_NONE) begin
                            d.perr = 1'b1;
                        end
                        if (mirror_here(q.dopt[`FSP_DOPT_ID_BIT],
                                        rx_byte[7:4])) begin
                            nxt = FSP_IDOFF;
                        end else if (mirror_here(q.dopt[`FSP_DOPT_CTR_BIT],
                                                 rx_byte[7:4])) begin
                            nxt = FSP_CTROFF;
                        end else begin
                            nxt = FSP_TAIL;
                        end
                    end
                    FSP_IDOFF: begin
                        d.idoff = {rx_byte, q.idoff[23:8]};
                        d.cnt   = 2'(q.cnt + 2'h1);
                        if (q.cnt == `FSP_OFF_LAST) begin
                            d.cnt = '0;
                            nxt = mirror_here(q.dopt[`FSP_DOPT_CTR_BIT],
                                              q.dacc[15:12])
                                  ? FSP_CTROFF : FSP_TAIL;
                        end
                    end
                    FSP_CTROFF: begin
                        d.ctroff = {rx_byte, q.ctroff[23:8]};
                        d.cnt    = 2'(q.cnt + 2'h1);
                        if (q.cnt == `FSP_OFF_LAST) begin
                            d.cnt = '0;
                            nxt = FSP_TAIL;
                        end
                    end
                    default: begin
                        nxt = q.st;
                    end
                endcase
            end
            d.st = nxt;

            if (rx_last && q.st != FSP_IDLE || rx_last && rx_first) begin
                d.st = FSP_IDLE;
                id_here  = d.fopt[`FSP_FOPT_DM_BIT] &&
                           mirror_here(d.dopt[`FSP_DOPT_ID_BIT],
                                       d.dacc[15:12]);
                ctr_here = d.fopt[`FSP_FOPT_DM_BIT] &&
                           mirror_here(d.dopt[`FSP_DOPT_CTR_BIT],
                                       d.dacc[15:12]);
                range_bad =
                    (id_here && !off_ok(d.idoff, mif.rd_data.size,
                                        24'(ID_LEN))) ||
                    (ctr_here && !off_ok(d.ctroff, mif.rd_data.size,
                                         24'(CTR_LEN)));
                if (nxt != FSP_TAIL) begin
                    code = `FSP_SW2_LENGTH;
                end else if (!mif.rd_data.exists) begin
                    code = `FSP_SW2_NO_FILE;
                end else if (d.perr || range_bad) begin
                    code = `FSP_SW2_PARAM;
                end
                if (!d.foreign) begin
                    d.resp_valid  = 1'b1;
                    d.resp_status = {`FSP_SW1, code};
                    d.last_code   = code;
                    d.upd_valid   = code == `FSP_SW2_OK;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q         <= '0;
            q.st      <= FSP_IDLE;
            q.meta    <= FSP_META_OFF;
            q.ctrl_en <= `FSP_CTRL_EN_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // The file lookup follows the file number as it is taken.
    assign mif.rd_addr = d.fnum;
    assign mif.we      = q.mem_we;
    assign mif.wr_addr = q.mem_wa;
    assign mif.wr_data = q.mem_wd;

    assign bus_rdata                  = q.rdata;
    assign resp_valid                 = q.resp_valid;
    assign resp_status                = q.resp_status;
    assign upd_valid                  = q.upd_valid;
    assign target_file_number         = q.fnum;
    assign file_option_byte           = q.fopt;
    assign file_access_word           = q.acc;
    assign dyn_msg_option_byte        = q.dopt;
    assign dyn_msg_access_word        = q.dacc;
    assign dyn_msg_features           = q.dm_feat;
    assign meta_read_mode             = q.meta;
    assign meta_read_key              = q.meta_key;
    assign identifier_mirror_offset   = q.idoff;
    assign read_counter_mirror_offset = q.ctroff;
    assign fully_protected_framing    = q.full;

endmodule : fsp_parser

// ---- tb/fsp_parser_checker.sv ----
`timescale 1ns/1ps
module fsp_parser_checker
    import fsp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        rx_valid,
    input wire logic        rx_last,
    input wire logic        bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic        resp_valid,
    input wire logic [15:0] resp_status,
    input wire logic        upd_valid,
    input wire logic [7:0]  file_option_byte,
    input wire logic [7:0]  dyn_msg_option_byte,
    input wire logic [15:0] dyn_msg_access_word,
    input wire logic [5:0]  dyn_msg_features,
    input wire fsp_meta_t   meta_read_mode,
    input wire logic [3:0]  meta_read_key,
    input wire logic [23:0] identifier_mirror_offset,
    input wire logic [23:0] read_counter_mirror_offset
);
    logic       dm;
    logic       last_in;
    logic [3:0] mr;
    assign dm      = upd_valid && file_option_byte[6];
    assign mr      = dyn_msg_access_word[15:12];
    assign last_in = rx_valid && rx_last && ce;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_SW1: assert property (
        resp_valid |-> resp_status[15:8] == 8'h91)
        else $error("status high byte wrong");
    AST_UPD_OK: assert property (
        upd_valid |-> resp_valid && resp_status[7:0] == 8'h00)
        else $error("update without success status");
    AST_OK_UPD: assert property (
        resp_valid && resp_status == 16'h9100 |-> upd_valid)
        else $error("success status without update");
    AST_RESP_TIME: assert property (resp_valid |-> $past(last_in))
        else $error("response not one cycle after last byte");
    AST_OPT_RSV: assert property (
        upd_valid |-> (file_option_byte & 8'hbc) == 8'h00)
        else $error("accepted reserved option bits");
    AST_DM_OFF: assert property (
        upd_valid && !file_option_byte[6]
        |-> dyn_msg_features == 6'h00 && identifier_mirror_offset == 24'h0)
        else $error("dynamic fields set while disabled");
    AST_FEAT: assert property (
        dm |-> dyn_msg_option_byte[2:1] == 2'b00 && dyn_msg_features
        == {dyn_msg_option_byte[7:3], dyn_msg_option_byte[0]})
        else $error("feature map wrong");
    AST_DACC_FIX: assert property (
        dm |-> dyn_msg_access_word[7:4] == 4'hf)
        else $error("fixed access nibble accepted wrong");
    AST_META: assert property (
        dm |-> meta_read_mode == (mr == 4'he ? FSP_META_PLAIN
        : mr == 4'hf ? FSP_META_OFF : FSP_META_ENC)
        && meta_read_key == (mr <= 4'h4 ? mr : 4'h0))
        else $error("meta decode wrong");
    AST_ID_ABS: assert property (
        upd_valid && !(dm && dyn_msg_option_byte[7] && mr == 4'he)
        |-> identifier_mirror_offset == 24'h0)
        else $error("identifier offset without field");
    AST_CTR_ABS: assert property (
        upd_valid && !(dm && dyn_msg_option_byte[6] && mr == 4'he)
        |-> read_counter_mirror_offset == 24'h0)
        else $error("counter offset without field");
    AST_RD_IDLE: assert property (!bus_rd |=> bus_rdata == 32'h0)
        else $error("read data outside read slot");
endmodule : fsp_parser_checker

bind fsp_parser fsp_parser_checker i_fsp_parser_checker (.clk, .rst, .ce,
    .rx_valid, .rx_last, .bus_rd, .bus_rdata, .resp_valid, .resp_status,
    .upd_valid, .file_option_byte, .dyn_msg_option_byte, .dyn_msg_access_word,
    .dyn_msg_features, .meta_read_mode, .meta_read_key,
    .identifier_mirror_offset, .read_counter_mirror_offset);

// ---- tb/fsp_reader.sv ----
`timescale 1ns/1ps
module fsp_reader (
    input wire logic  clk,
    output logic      rx_valid,
    output logic      rx_first,
    output logic      rx_last,
    output logic [7:0] rx_byte
);
    initial begin
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_last  = 1'b0;
        rx_byte  = 8'h00;
    end

    // Sends a frame one byte per cycle; the byte lane is inverted after it.
    task automatic send(input logic [7:0] fr [$]);
        for (int i = 0; i < fr.size(); i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_first <= (i == 0);
            rx_last  <= (i == fr.size() - 1);
            rx_byte  <= fr[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_first <= 1'b0;
        rx_last  <= 1'b0;
        rx_byte  <= ~rx_byte;
    endtask : send
endmodule : fsp_reader

// ---- tb/fsp_parser_tb.sv ----
`timescale 1ns/1ps
module fsp_parser_tb;
    import fsp_pkg::*;
    logic clk, rst, ce, bus_wr, bus_rd, rx_valid, rx_first, rx_last;
    logic resp_valid, upd_valid, fully_protected_framing, last_upd;
    logic [7:0] bus_addr, rx_byte, file_option_byte, dyn_msg_option_byte;
    logic [31:0] bus_wdata, bus_rdata, d;
    logic [15:0] resp_status, file_access_word, dyn_msg_access_word, last_st;
    logic [4:0] target_file_number;
    logic [5:0] dyn_msg_features;
    logic [3:0] meta_read_key;
    logic [23:0] identifier_mirror_offset, read_counter_mirror_offset;
    fsp_meta_t meta_read_mode;
    int fail_count = 0;
    int checks = 0;
    int resp_n = 0;

    fsp_parser i_fsp_parser (.clk(clk), .rst(rst), .ce(ce),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_valid(rx_valid),
        .rx_first(rx_first), .rx_last(rx_last), .rx_byte(rx_byte),
        .resp_valid(resp_valid), .resp_status(resp_status),
        .upd_valid(upd_valid), .target_file_number(target_file_number),
        .file_option_byte(file_option_byte),
        .file_access_word(file_access_word),
        .dyn_msg_option_byte(dyn_msg_option_byte),
        .dyn_msg_access_word(dyn_msg_access_word),
        .dyn_msg_features(dyn_msg_features),
        .meta_read_mode(meta_read_mode), .meta_read_key(meta_read_key),
        .identifier_mirror_offset(identifier_mirror_offset),
        .read_counter_mirror_offset(read_counter_mirror_offset),
        .fully_protected_framing(fully_protected_framing));
    fsp_reader i_fsp_reader (.clk(clk), .rx_valid(rx_valid),
        .rx_first(rx_first), .rx_last(rx_last), .rx_byte(rx_byte));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (resp_valid === 1'b1) begin
            resp_n++;
            last_st = resp_status;
            last_upd = upd_valid;
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_val(input string nm, input logic [31:0] exp,
                           input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_val

    task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= v;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1 v = bus_rdata;
    endtask : bus_read

    // A code with bit 8 set means no response is expected.
    task automatic run(input logic [7:0] fr [$], input logic [8:0] code);
        int n0;
        n0 = resp_n;
        i_fsp_reader.send(fr);
        repeat (3) @(posedge clk);
        if (code[8]) begin
            chk_val("silent", n0, resp_n);
        end else begin
            chk_val("count", n0 + 1, resp_n);
            chk_val("status", {16'h0, 8'h91, code[7:0]}, {16'h0, last_st});
            chk_val("update", {31'h0, code[7:0] == 8'h00}, {31'h0, last_upd});
        end
    endtask : run

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus_read(8'h00, d);
        chk_val("ctrl", 32'h1, d);
        bus_read(8'h20, d);
        chk_val("unmapped", 32'h0, d);
        bus_write(8'h04, 32'h3);
        bus_write(8'h08, 32'h0200_0100);
        bus_write(8'h04, 32'h5);
        bus_write(8'h08, 32'h0300_0040);
        ce <= 1'b0;
        bus_write(8'h04, 32'h9);
        ce <= 1'b1;
        bus_read(8'h04, d);
        chk_val("sel", 32'h5, d);
        run('{8'h5f, 8'h03, 8'h00, 8'hee, 8'hee}, 9'h000);
        chk_val("framing", 32'h0, {31'h0, fully_protected_framing});
        bus_read(8'h10, d);
        chk_val("result", 32'h0300_eeee, d);
        run('{8'h5f, 8'h05, 8'h40, 8'h11, 8'h22, 8'hc1, 8'hfe, 8'hef,
              8'h10, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00}, 9'h000);
        chk_val("framing", 32'h1, {31'h0, fully_protected_framing});
        chk_val("access", 32'h2211, {16'h0, file_access_word});
        chk_val("features", 32'h31, {26'h0, dyn_msg_features});
        chk_val("dacc", 32'heffe, {16'h0, dyn_msg_access_word});
        chk_val("meta", 32'h1, {30'h0, meta_read_mode});
        chk_val("id off", 32'h10, {8'h0, identifier_mirror_offset});
        chk_val("ctr off", 32'h20, {8'h0, read_counter_mirror_offset});
        chk_val("file no", 32'h5, {27'h0, target_file_number});
        chk_val("option", 32'h40, {24'h0, file_option_byte});
        chk_val("dyn opt", 32'hc1, {24'h0, dyn_msg_option_byte});
        run('{8'h5f, 8'h05, 8'h41, 8'h00, 8'h00, 8'h80, 8'hff, 8'h3f,
              8'haa}, 9'h000);
        chk_val("meta", 32'h2, {30'h0, meta_read_mode});
        chk_val("key", 32'h3, {28'h0, meta_read_key});
        chk_val("features", 32'h20, {26'h0, dyn_msg_features});
        chk_val("id off", 32'h0, {8'h0, identifier_mirror_offset});
        run('{8'h5f, 8'h07, 8'h00, 8'h00, 8'h00}, 9'h0f0);
        run('{8'h5f, 8'h03, 8'h80, 8'h00, 8'h00}, 9'h09e);
        run('{8'h5f, 8'h23, 8'h00, 8'h00, 8'h00}, 9'h09e);
        run('{8'h5f, 8'h05, 8'h40, 8'h00, 8'h00, 8'h04, 8'hff,
              8'hff}, 9'h09e);
        run('{8'h5f, 8'h05, 8'h40, 8'h00, 8'h00, 8'h00, 8'h0f,
              8'hee}, 9'h09e);
        run('{8'h5f, 8'h05, 8'h40, 8'h00, 8'h00, 8'h80, 8'hff, 8'hef,
              8'h3a, 8'h00, 8'h00}, 9'h09e);
        run('{8'h5f, 8'h05, 8'h40, 8'h00, 8'h00, 8'h40, 8'hff, 8'hef,
              8'h3e, 8'h00, 8'h00}, 9'h09e);
        run('{8'h5f, 8'h05, 8'h40, 8'h00, 8'h00, 8'h80, 8'hff, 8'hef,
              8'h10}, 9'h07e);
        run('{8'h5f, 8'h03, 8'h00}, 9'h07e);
        run('{8'h60, 8'h03, 8'h00, 8'h00, 8'h00}, 9'h100);
        run('{8'h5f, 8'h05, 8'h40, 8'h00, 8'h00, 8'h00, 8'hff,
              8'h5f}, 9'h09e);
        bus_read(8'h0c, d);
        chk_val("last code", 32'h0000_9e00, d);
        bus_write(8'h00, 32'h0);
        run('{8'h5f, 8'h03, 8'h00, 8'hee, 8'hee}, 9'h100);
        bus_write(8'h00, 32'h1);
        run('{8'h5f, 8'h03, 8'h00, 8'hee, 8'hee}, 9'h000);
        report_and_stop();
    end
endmodule : fsp_parser_tb
